// [hw/gdio_pkg.sv]
// package for the general digital io port: widths, offsets, reset values
package gdio_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int GDIO_PORTS = 4;
    localparam int GDIO_PINS = 8;
    localparam int GDIO_ADDR_W = 4;
    localparam int GDIO_DATA_W = 8;

    // ------------------------------------------------------------
    // register map: three locations per port, then the control reg
    // ------------------------------------------------------------
    localparam logic [3:0] GDIO_OFS_INPUT = 4'h0;
    localparam logic [3:0] GDIO_OFS_DIR = 4'h1;
    localparam logic [3:0] GDIO_OFS_OUT = 4'h2;
    localparam logic [3:0] GDIO_LOC_PER_PORT = 4'h3;
    localparam logic [3:0] GDIO_ADDR_CTRL = 4'hc;
    localparam int GDIO_CTRL_PUD_BIT = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GDIO_RST_DIR = 8'h00;
    localparam logic [7:0] GDIO_RST_OUT = 8'h00;
    localparam logic [7:0] GDIO_RST_SYNC = 8'h00;
    localparam logic [7:0] GDIO_READ_ZERO = 8'h00;

    // ------------------------------------------------------------
    // pin mode
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        GDIO_MODE_HIZ = 4'h1,
        GDIO_MODE_PULLUP = 4'h2,
        GDIO_MODE_OUT_LOW = 4'h4,
        GDIO_MODE_OUT_HIGH = 4'h8
    } gdio_mode_t;
endpackage : gdio_pkg

// [hw/gdio_pin.sv]
// one pin slice: sleep clamp, input synchroniser and pin drive
module gdio_pin
    import gdio_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic pin_in,
    input wire logic sleep_clamp,
    input wire logic ext_irq_enable,
    input wire logic pin_direction_bit,
    input wire logic pin_output_value_bit,
    input wire logic global_pullup_disable,
    output logic pin_input_sample_bit,
    output logic pin_out,
    output logic pin_oe_n,
    output logic pin_pullup
);
    logic clamped;
    logic sync_latch;
    gdio_mode_t next_mode;

    // ------------------------------------------------------------
    // sleep clamp ahead of the input stage
    // ------------------------------------------------------------
    // an enabled external interrupt keeps its pin live in sleep
    assign clamped = pin_in & ~(sleep_clamp & ~ext_irq_enable);

    // ------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------
    // the half-period latch is modelled as a negedge flop, the
    // sample bit loads it on the next rising edge only
    always_ff @(negedge clock) begin
        sync_latch <= clamped;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pin_input_sample_bit <= 1'b0;
        end else begin
            pin_input_sample_bit <= sync_latch;
        end
    end

    // ------------------------------------------------------------
    // drive decode
    // ------------------------------------------------------------
    always_comb begin
        case ({pin_direction_bit, pin_output_value_bit})
            2'b00: next_mode = GDIO_MODE_HIZ;
            2'b01: next_mode = global_pullup_disable ? GDIO_MODE_HIZ : GDIO_MODE_PULLUP;
            2'b10: next_mode = GDIO_MODE_OUT_LOW;
            2'b11: next_mode = GDIO_MODE_OUT_HIGH;
            default: next_mode = GDIO_MODE_HIZ;
        endcase
    end

    // outputs are flopped: one cycle after the register bits change
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_oe_n <= 1'b1;
            pin_out <= 1'b0;
            pin_pullup <= 1'b0;
        end else begin
            case (next_mode)
                GDIO_MODE_PULLUP: begin
                    pin_oe_n <= 1'b1;
                    pin_out <= 1'b0;
                    pin_pullup <= 1'b1;
                end
                GDIO_MODE_OUT_LOW: begin
                    pin_oe_n <= 1'b0;
                    pin_out <= 1'b0;
                    pin_pullup <= 1'b0;
                end
                GDIO_MODE_OUT_HIGH: begin
                    pin_oe_n <= 1'b0;
                    pin_out <= 1'b1;
                    pin_pullup <= 1'b0;
                end
                default: begin
                    pin_oe_n <= 1'b1;
                    pin_out <= 1'b0;
                    pin_pullup <= 1'b0;
                end
            endcase
        end
    end
endmodule : gdio_pin

// [hw/gdio_port.sv]
// general digital io block: four 8-bit ports behind a plain register port
module gdio_port
    import gdio_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [gdio_pkg::GDIO_ADDR_W-1:0] reg_addr,
    input wire logic [gdio_pkg::GDIO_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [gdio_pkg::GDIO_DATA_W-1:0] reg_rdata,
    input wire logic sleep_clamp,
    input wire logic [gdio_pkg::GDIO_PORTS*gdio_pkg::GDIO_PINS-1:0] ext_irq_enable,
    input wire logic [gdio_pkg::GDIO_PORTS*gdio_pkg::GDIO_PINS-1:0] pin_in,
    output logic [gdio_pkg::GDIO_PORTS*gdio_pkg::GDIO_PINS-1:0] pin_out,
    output logic [gdio_pkg::GDIO_PORTS*gdio_pkg::GDIO_PINS-1:0] pin_oe_n,
    output logic [gdio_pkg::GDIO_PORTS*gdio_pkg::GDIO_PINS-1:0] pin_pullup,
    output logic global_pullup_disable
);
    import gdio_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [GDIO_DATA_W-1:0] port_direction_reg [GDIO_PORTS];
    logic [GDIO_DATA_W-1:0] port_output_value_reg [GDIO_PORTS];
    logic [GDIO_DATA_W-1:0] port_input_sample_reg [GDIO_PORTS];
    logic [GDIO_PORTS-1:0] wr_direction_strobe;
    logic [GDIO_PORTS-1:0] wr_output_strobe;
    logic [GDIO_PORTS-1:0] wr_input_toggle_strobe;
    logic [GDIO_PORTS-1:0] rd_direction_strobe;
    logic [GDIO_PORTS-1:0] rd_output_strobe;
    logic [GDIO_PORTS-1:0] rd_pin_strobe;
    logic wr_ctrl;
    logic rd_ctrl;
    logic [GDIO_DATA_W-1:0] next_rdata;

    assign wr_ctrl = reg_write && (reg_addr == GDIO_ADDR_CTRL);
    assign rd_ctrl = reg_read && (reg_addr == GDIO_ADDR_CTRL);

    // ------------------------------------------------------------
    // per-port strobes, registers and pins
    // ------------------------------------------------------------
    genvar p;
    genvar n;
    generate
        for (p = 0; p < GDIO_PORTS; p++) begin : g_port
            localparam logic [3:0] BASE = 4'(p) * GDIO_LOC_PER_PORT;

            // one strobe set per port, shared by its pins
            assign wr_input_toggle_strobe[p] = reg_write && (reg_addr == BASE + GDIO_OFS_INPUT);
            assign wr_direction_strobe[p] = reg_write && (reg_addr == BASE + GDIO_OFS_DIR);
            assign wr_output_strobe[p] = reg_write && (reg_addr == BASE + GDIO_OFS_OUT);
            assign rd_pin_strobe[p] = reg_read && (reg_addr == BASE + GDIO_OFS_INPUT);
            assign rd_direction_strobe[p] = reg_read && (reg_addr == BASE + GDIO_OFS_DIR);
            assign rd_output_strobe[p] = reg_read && (reg_addr == BASE + GDIO_OFS_OUT);

            always_ff @(posedge clock) begin
                if (srst) begin
                    port_direction_reg[p] <= GDIO_RST_DIR;
                end else if (wr_direction_strobe[p]) begin
                    port_direction_reg[p] <= reg_wdata;
                end
            end

            // toggle through the input location does not depend on direction
            always_ff @(posedge clock) begin
                if (srst) begin
                    port_output_value_reg[p] <= GDIO_RST_OUT;
                end else if (wr_output_strobe[p]) begin
                    port_output_value_reg[p] <= reg_wdata;
                end else if (wr_input_toggle_strobe[p]) begin
                    port_output_value_reg[p] <= port_output_value_reg[p] ^ reg_wdata;
                end
            end

            for (n = 0; n < GDIO_PINS; n++) begin : g_pin
                gdio_pin u_pin (
                    .clock(clock),
                    .srst(srst),
                    .pin_in(pin_in[p*GDIO_PINS+n]),
                    .sleep_clamp(sleep_clamp),
                    .ext_irq_enable(ext_irq_enable[p*GDIO_PINS+n]),
                    .pin_direction_bit(port_direction_reg[p][n]),
                    .pin_output_value_bit(port_output_value_reg[p][n]),
                    .global_pullup_disable(global_pullup_disable),
                    .pin_input_sample_bit(port_input_sample_reg[p][n]),
                    .pin_out(pin_out[p*GDIO_PINS+n]),
                    .pin_oe_n(pin_oe_n[p*GDIO_PINS+n]),
                    .pin_pullup(pin_pullup[p*GDIO_PINS+n])
                );
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            global_pullup_disable <= 1'b0;
        end else if (wr_ctrl) begin
            global_pullup_disable <= reg_wdata[GDIO_CTRL_PUD_BIT];
        end
    end

    // ------------------------------------------------------------
    // read mux; input location has no storage of its own to write
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = GDIO_READ_ZERO;
        for (int i = 0; i < GDIO_PORTS; i++) begin
            if (rd_pin_strobe[i]) begin
                next_rdata = port_input_sample_reg[i];
            end
            if (rd_direction_strobe[i]) begin
                next_rdata = port_direction_reg[i];
            end
            if (rd_output_strobe[i]) begin
                next_rdata = port_output_value_reg[i];
            end
        end
        if (rd_ctrl) begin
            next_rdata[GDIO_CTRL_PUD_BIT] = global_pullup_disable;
        end
    end

    // unmapped or idle reads return zero
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= GDIO_READ_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule : gdio_port

// [tb/gdio_port_chk.sv]
// assertion checker for the general digital io port
module gdio_chk import gdio_pkg::*; (
    input wire logic clock, srst, reg_write, reg_read, sleep_clamp, global_pullup_disable,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire logic [31:0] ext_irq_enable, pin_in, pin_out, pin_oe_n, pin_pullup
);
    logic [7:0] out0, irq0;
    assign out0 = pin_out[7:0];
    assign irq0 = ext_irq_enable[7:0];
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // ----------------------------------------
    // pin drive and register reads, port 0 stands for all ports
    // ----------------------------------------
    chk_reset_tristate: assert property ($fell(srst)
        |-> &pin_oe_n && pin_pullup == 32'h0) else $error("pins active out of reset");
    chk_no_pull_drive: assert property ((pin_pullup & ~pin_oe_n) == 32'h0)
        else $error("pull-up on a driving pin");
    chk_pud_all_off: assert property (global_pullup_disable && $past(global_pullup_disable)
        |-> pin_pullup == 32'h0) else $error("pull-up despite global disable");
    chk_dir_to_oe: assert property (reg_write && reg_addr == GDIO_OFS_DIR
        |=> ##1 pin_oe_n[7:0] == ~$past(reg_wdata, 2)) else $error("enable misses direction");
    chk_out_to_pin: assert property (reg_write && reg_addr == GDIO_OFS_OUT
        |=> ##1 (out0 | pin_oe_n[7:0]) == ($past(reg_wdata, 2) | pin_oe_n[7:0]))
        else $error("drive misses output value");
    chk_toggle_out: assert property (reg_write && reg_addr == GDIO_OFS_INPUT && !$past(reg_write)
        |=> ##1 ((out0 ^ $past(out0)) | pin_oe_n[7:0]) == ($past(reg_wdata, 2) | pin_oe_n[7:0]))
        else $error("toggle wrong");
    chk_read_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_clamp_zero: assert property (reg_read && reg_addr == GDIO_OFS_INPUT && sleep_clamp
        && $past(sleep_clamp) && irq0 == 8'h00 && $past(irq0) == 8'h00 |=> reg_rdata == 8'h00)
        else $error("clamped input reads high");
    cover property (reg_write && reg_addr == GDIO_OFS_INPUT);
    cover property (sleep_clamp && reg_read);
    cover property (pin_pullup != 32'h0);
endmodule : gdio_chk
bind gdio_port gdio_chk chk_u (.*);

// [tb/gdio_pads.sv]
// pad model: external circuitry and pull-ups on the port pins
module gdio_pads (
    input wire logic clock,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic [31:0] pin_pullup,
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_val,
    output logic [31:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] flt = 32'h0;
    // undriven pads without a pull-up wander so a missing drive never reads as a clean level
    always_ff @(posedge clock) begin
        flt <= ~flt;
    end
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en & (pin_pullup | flt));
endmodule : gdio_pads

// [tb/test_general_digital_io_port.sv]
// self-checking bench for the general digital io port
module test_general_digital_io_port;
    import gdio_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, srst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, sleep_clamp = 1'b0;
    logic global_pullup_disable;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [31:0] ext_irq_enable = 32'h0, ext_en = 32'h0, ext_val = 32'h0;
    logic [31:0] pin_in, pin_out, pin_oe_n, pin_pullup;
    int n_errors = 0, compares = 0;
    gdio_port dut_u (.*);
    gdio_pads pads_u (.*);

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        // idle cycle keeps strobes apart and lets the pins settle
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        cmp({24'h0, reg_rdata}, {24'h0, exp});
    endtask : rd

    task automatic t_drive();
        logic [7:0] d;
        for (int p = 0; p < 4; p++) begin
            d = 8'hf5 ^ 8'(p);
            wr(4'(3 * p) + GDIO_OFS_OUT, d);
            wr(4'(3 * p) + GDIO_OFS_DIR, 8'h0f);
            @(posedge clock);
            cmp(32'(pin_oe_n[8 * p +: 8]), 32'hf0);
            cmp(32'(pin_out[8 * p +: 4]), 32'(d[3:0]));
            cmp(32'(pin_pullup[8 * p +: 8]), 32'hf0);
            rd(4'(3 * p) + GDIO_OFS_DIR, 8'h0f);
            rd(4'(3 * p) + GDIO_OFS_INPUT, d);
        end
        $display("drive test done");
    endtask : t_drive

    task automatic t_pud();
        wr(GDIO_ADDR_CTRL, 8'(1 << GDIO_CTRL_PUD_BIT));
        @(posedge clock);
        cmp(pin_pullup, 32'h0);
        rd(GDIO_ADDR_CTRL, 8'(1 << GDIO_CTRL_PUD_BIT));
        rd(4'hd, 8'h00);
        wr(GDIO_ADDR_CTRL, 8'h00);
        @(posedge clock);
        cmp(pin_pullup, 32'hf0f0f0f0);
        wr(GDIO_OFS_INPUT, 8'hff);
        rd(GDIO_OFS_OUT, 8'h0a);
        cmp(32'(pin_pullup[7:0]), 32'h0);
        $display("pull-up and toggle test done");
    endtask : t_pud

    task automatic t_input();
        ext_en <= 32'h0000f000;
        rd(4'h3, 8'hf4);
        rd(4'h3, 8'h04);
        ext_val <= 32'h0000f000;
        ext_irq_enable <= 32'h00004000;
        sleep_clamp <= 1'b1;
        repeat (3) @(posedge clock);
        rd(GDIO_OFS_INPUT, 8'h00);
        rd(4'h3, 8'h40);
        sleep_clamp <= 1'b0;
        ext_irq_enable <= 32'h0;
        repeat (3) @(posedge clock);
        rd(4'h3, 8'hf4);
        $display("input test done");
    endtask : t_input

    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    initial begin
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (2000) @(posedge clock);
        n_errors++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge clock);
        cmp(pin_oe_n, 32'hffffffff);
        cmp(pin_pullup, 32'h0);
        srst <= 1'b0;
        @(posedge clock);
        rd(GDIO_OFS_DIR, 8'h00);
        rd(GDIO_OFS_OUT, 8'h00);
        t_drive();
        t_pud();
        t_input();
        conclude();
    end
endmodule : test_general_digital_io_port
